// >>> verilog/tsd_status_bank.sv
// Tile processor status and debug register bank
//
// Overview of operation
// - Four free-running oscillators outside the core clock each advance their own counter.
// - Control bit 1 runs the core oscillators, bit 0 the peripheral ones, both reset low.
// - Four read-only registers give the 16-bit counts in core cell, core wire, peripheral cell, peripheral wire order.
// - Reset leaves the oscillator counts untouched.
// - A read-only register gives the RAM size in bytes in bits 31:2.
// - Debugger entry copies the interrupted thread's status word with bit 5 cleared.
// - The status copy keeps its documented bit layout with bits 8 and 5 read-only.
// - Debugger entry copies the saved program counter and stack pointer.
// - Register-read operands hold the thread number in bits 7:0 and register number in bits 4:0.
// - The cause field in bits 2:0 encodes host, debug call, breakpoint, data and resource watch, resetting to 0.
// - Bits 17:16 record the lowest firing comparator index, zero for host and debug call.
// - Bits 15:8 record the causing thread, zero for host entry.
// - The event data word holds the address for data watch and the resource id for resource watch.
// - Set stop-mask bits hold their threads still outside debug mode.
// - Eight scratch words are shared between this port and the tile configuration port.
`default_nettype none

module tsd_status_bank (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Status set and get access from the cores
  input wire logic ps_wr_i,
  input wire logic ps_rd_i,
  input wire logic [tsd_pkg::ADDR_W-1:0] ps_addr_i,
  input wire logic [tsd_pkg::DATA_W-1:0] ps_wdata_i,
  output logic [tsd_pkg::DATA_W-1:0] ps_rdata_o,
  output logic ps_rvalid_o,
  // Tile configuration access to the scratch words
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [tsd_pkg::SCR_IDX_W-1:0] cfg_idx_i,
  input wire logic [tsd_pkg::DATA_W-1:0] cfg_wdata_i,
  output logic [tsd_pkg::DATA_W-1:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Debug state from the pipeline
  input wire logic dbg_mode_i,
  input wire logic dbg_enter_i,
  input wire logic [tsd_pkg::CAUSE_W-1:0] dbg_cause_i,
  input wire logic [tsd_pkg::CTHREAD_W-1:0] dbg_thread_i,
  input wire logic [tsd_pkg::HIT_W-1:0] dbg_hit_i,
  input wire logic [tsd_pkg::DATA_W-1:0] dbg_addr_i,
  input wire logic [tsd_pkg::DATA_W-1:0] dbg_res_i,
  input wire logic [tsd_pkg::SSR_W-1:0] dbg_sr_i,
  input wire logic [tsd_pkg::DATA_W-1:0] dbg_pc_i,
  input wire logic [tsd_pkg::DATA_W-1:0] dbg_sp_i,
  // Ring oscillator outputs and enables
  input wire logic [tsd_pkg::OSC_NUM-1:0] ring_osc_i,
  output logic core_osc_en_o,
  output logic periph_osc_en_o,
  // Operands for the debug register read and thread holds
  output logic [tsd_pkg::RR_THREAD_W-1:0] regread_thread_o,
  output logic [tsd_pkg::RR_REGNUM_W-1:0] regread_regnum_o,
  output logic [tsd_pkg::THREADS-1:0] thread_stop_o
);

  // Merge a write into a register under a per-bit write mask
  function automatic logic [31:0] merge_wr(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [31:0] msk);
    merge_wr = (old_v & ~msk) | (new_v & msk);
  endfunction : merge_wr

  // Index of the lowest set comparator hit
  function automatic logic [1:0] lowest_hit(input logic [3:0] hit);
    lowest_hit = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (hit[i])
      begin
        lowest_hit = 2'(i);
      end
    end
  endfunction : lowest_hit

  // Address decode and write strobes
  logic wr_any;
  logic dbg_wr;
  logic hit_osc_ctrl;
  logic hit_scr;

  assign wr_any = ps_wr_i;
  // Debug fields take writes only while the tile is in debug mode
  assign dbg_wr = ps_wr_i & dbg_mode_i;
  assign hit_osc_ctrl = (ps_addr_i == tsd_pkg::OFF_OSC_CTRL);
  assign hit_scr = (ps_addr_i >= tsd_pkg::OFF_SCR_FIRST) &&
                   (ps_addr_i <= tsd_pkg::OFF_SCR_LAST);

  // Control group: oscillator enables, operands and stop mask
  logic [1:0] osc_ctrl_r;
  logic [1:0] osc_ctrl_nxt;
  logic [tsd_pkg::RR_THREAD_W-1:0] rr_thread_r;
  logic [tsd_pkg::RR_THREAD_W-1:0] rr_thread_nxt;
  logic [tsd_pkg::RR_REGNUM_W-1:0] rr_regnum_r;
  logic [tsd_pkg::RR_REGNUM_W-1:0] rr_regnum_nxt;
  logic [tsd_pkg::THREADS-1:0] stop_mask_r;
  logic [tsd_pkg::THREADS-1:0] stop_mask_nxt;
  logic [tsd_pkg::THREADS-1:0] stop_out_r;
  logic [tsd_pkg::THREADS-1:0] stop_out_nxt;

  always_comb
  begin
    osc_ctrl_nxt = osc_ctrl_r;
    rr_thread_nxt = rr_thread_r;
    rr_regnum_nxt = rr_regnum_r;
    stop_mask_nxt = stop_mask_r;
    // Oscillator control is plain read-write; upper bits are dropped
    if (wr_any && hit_osc_ctrl)
    begin
      osc_ctrl_nxt = ps_wdata_i[1:0];
    end
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_RR_THREAD)
    begin
      rr_thread_nxt = ps_wdata_i[tsd_pkg::RR_THREAD_W-1:0];
    end
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_RR_REGNUM)
    begin
      rr_regnum_nxt = ps_wdata_i[tsd_pkg::RR_REGNUM_W-1:0];
    end
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_STOP_MASK)
    begin
      stop_mask_nxt = ps_wdata_i[tsd_pkg::THREADS-1:0];
    end
    // Holds are released for the whole of debug mode, so the debug
    // handler itself can inspect any thread
    stop_out_nxt = dbg_mode_i ? '0 : stop_mask_nxt;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      osc_ctrl_r <= tsd_pkg::OSC_CTRL_RST;
      rr_thread_r <= '0;
      rr_regnum_r <= '0;
      stop_mask_r <= '0;
      stop_out_r <= '0;
    end
    else
    begin
      osc_ctrl_r <= osc_ctrl_nxt;
      rr_thread_r <= rr_thread_nxt;
      rr_regnum_r <= rr_regnum_nxt;
      stop_mask_r <= stop_mask_nxt;
      stop_out_r <= stop_out_nxt;
    end
  end

  // Debug capture group: status, PC, SP copies, cause and data
  logic [tsd_pkg::SSR_W-1:0] ssr_r;
  logic [tsd_pkg::SSR_W-1:0] ssr_nxt;
  logic [31:0] spc_r;
  logic [31:0] spc_nxt;
  logic [31:0] ssp_r;
  logic [31:0] ssp_nxt;
  logic [tsd_pkg::CAUSE_W-1:0] cause_r;
  logic [tsd_pkg::CAUSE_W-1:0] cause_nxt;
  logic [tsd_pkg::CTHREAD_W-1:0] cthread_r;
  logic [tsd_pkg::CTHREAD_W-1:0] cthread_nxt;
  logic [tsd_pkg::CIDX_W-1:0] cidx_r;
  logic [tsd_pkg::CIDX_W-1:0] cidx_nxt;
  logic [31:0] evt_data_r;
  logic [31:0] evt_data_nxt;

  always_comb
  begin
    ssr_nxt = ssr_r;
    spc_nxt = spc_r;
    ssp_nxt = ssp_r;
    cause_nxt = cause_r;
    cthread_nxt = cthread_r;
    cidx_nxt = cidx_r;
    evt_data_nxt = evt_data_r;
    // Software writes; bit 8 and bit 5 of the status copy are kept
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_SSR_COPY)
    begin
      ssr_nxt = 11'(merge_wr(32'(ssr_r), ps_wdata_i,
                             32'(tsd_pkg::SSR_WR_MASK)));
    end
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_SPC_COPY)
    begin
      spc_nxt = ps_wdata_i;
    end
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_SSP_COPY)
    begin
      ssp_nxt = ps_wdata_i;
    end
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_CAUSE)
    begin
      cause_nxt = ps_wdata_i[tsd_pkg::CAUSE_LSB +: tsd_pkg::CAUSE_W];
      cthread_nxt = ps_wdata_i[tsd_pkg::CTHREAD_LSB +: tsd_pkg::CTHREAD_W];
      cidx_nxt = ps_wdata_i[tsd_pkg::CIDX_LSB +: tsd_pkg::CIDX_W];
    end
    if (dbg_wr && ps_addr_i == tsd_pkg::OFF_EVT_DATA)
    begin
      evt_data_nxt = ps_wdata_i;
    end
    // Debugger entry overrides a same-cycle software write, except to the data word on causes other than data and resource watch
    if (dbg_enter_i)
    begin
      ssr_nxt = dbg_sr_i & ~11'h020;
      spc_nxt = dbg_pc_i;
      ssp_nxt = dbg_sp_i;
      cause_nxt = dbg_cause_i;
      cthread_nxt = (dbg_cause_i == tsd_pkg::CAUSE_HOST) ?
                    '0 : dbg_thread_i;
      if (dbg_cause_i == tsd_pkg::CAUSE_HOST ||
          dbg_cause_i == tsd_pkg::CAUSE_DEBUG_CALL_INSTRUCTION)
      begin
        cidx_nxt = '0;
      end
      else
      begin
        cidx_nxt = lowest_hit(dbg_hit_i);
      end
      // Other causes leave the data word as it was
      if (dbg_cause_i == tsd_pkg::CAUSE_DWATCH)
      begin
        evt_data_nxt = dbg_addr_i;
      end
      else if (dbg_cause_i == tsd_pkg::CAUSE_RWATCH)
      begin
        evt_data_nxt = dbg_res_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ssr_r <= tsd_pkg::SSR_RST;
      spc_r <= tsd_pkg::WORD_RST;
      ssp_r <= tsd_pkg::WORD_RST;
      cause_r <= tsd_pkg::CAUSE_RST;
      cthread_r <= '0;
      cidx_r <= '0;
      evt_data_r <= tsd_pkg::WORD_RST;
    end
    else
    begin
      ssr_r <= ssr_nxt;
      spc_r <= spc_nxt;
      ssp_r <= ssp_nxt;
      cause_r <= cause_nxt;
      cthread_r <= cthread_nxt;
      cidx_r <= cidx_nxt;
      evt_data_r <= evt_data_nxt;
    end
  end

  // Oscillator counter group: no reset, so counts survive it
  logic [tsd_pkg::OSC_NUM-1:0] osc_prev_r;
  // Counts start at zero at power-up only; a system reset leaves them
  logic [tsd_pkg::OSC_CNT_W-1:0] osc_cnt_r [tsd_pkg::OSC_NUM] = '{default: '0};
  logic [tsd_pkg::OSC_CNT_W-1:0] osc_cnt_nxt [tsd_pkg::OSC_NUM];
  logic [tsd_pkg::OSC_NUM-1:0] osc_run;

  // Counters 0,1 follow the core enable, 2,3 the peripheral one
  assign osc_run = {{2{osc_ctrl_r[tsd_pkg::OSC_PERIPH_BIT]}},
                    {2{osc_ctrl_r[tsd_pkg::OSC_CORE_BIT]}}};

  always_comb
  begin
    for (int i = 0; i < tsd_pkg::OSC_NUM; i++)
    begin
      osc_cnt_nxt[i] = osc_cnt_r[i];
      // Each rising oscillator edge advances its own counter
      if (osc_run[i] && ring_osc_i[i] && !osc_prev_r[i])
      begin
        osc_cnt_nxt[i] = osc_cnt_r[i] + 16'h0001;
      end
    end
  end

  // Deliberately unreset so the random state is kept across reset
  always_ff @(posedge sys_clk_i)
  begin
    osc_prev_r <= ring_osc_i;
    for (int i = 0; i < tsd_pkg::OSC_NUM; i++)
    begin
      osc_cnt_r[i] <= osc_cnt_nxt[i];
    end
  end

  // Scratch memory shared with the configuration port
  tsd_scratch_if scr_if ();

  // Core-side write wins a same-cycle clash with the config port
  always_comb
  begin
    scr_if.wr_en = (dbg_wr && hit_scr) || cfg_wr_i;
    scr_if.wr_idx = (dbg_wr && hit_scr) ?
                    ps_addr_i[tsd_pkg::SCR_IDX_W-1:0] : cfg_idx_i;
    scr_if.wr_data = (dbg_wr && hit_scr) ? ps_wdata_i : cfg_wdata_i;
    scr_if.rd_a_idx = ps_addr_i[tsd_pkg::SCR_IDX_W-1:0];
    scr_if.rd_b_idx = cfg_idx_i;
  end

  tsd_scratch_mem u_scr_mem (
    .sys_clk_i (sys_clk_i),
    .mem_if (scr_if.mem)
  );

  // Read pipeline: select in cycle 0, scratch out in 1, answer in 2
  logic [31:0] rd_val;
  logic rd_pend_r;
  logic rd_pend_nxt;
  logic rd_scr_r;
  logic rd_scr_nxt;
  logic [31:0] rd_hold_r;
  logic [31:0] rd_hold_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic cfg_rvalid_r;
  logic cfg_rvalid_nxt;

  // Register read mux; reserved bits and unmapped numbers read zero
  always_comb
  begin
    rd_val = '0;
    unique case (ps_addr_i)
      tsd_pkg::OFF_OSC_CTRL: rd_val = 32'(osc_ctrl_r);
      tsd_pkg::OFF_CC_CNT: rd_val = 32'(osc_cnt_r[0]);
      tsd_pkg::OFF_CW_CNT: rd_val = 32'(osc_cnt_r[1]);
      tsd_pkg::OFF_PC_CNT: rd_val = 32'(osc_cnt_r[2]);
      tsd_pkg::OFF_PW_CNT: rd_val = 32'(osc_cnt_r[3]);
      tsd_pkg::OFF_RAM_SIZE:
        rd_val = tsd_pkg::RAM_SIZE_BYTES & tsd_pkg::RAM_SIZE_MASK;
      tsd_pkg::OFF_SSR_COPY: rd_val = 32'(ssr_r);
      tsd_pkg::OFF_SPC_COPY: rd_val = spc_r;
      tsd_pkg::OFF_SSP_COPY: rd_val = ssp_r;
      tsd_pkg::OFF_RR_THREAD: rd_val = 32'(rr_thread_r);
      tsd_pkg::OFF_RR_REGNUM: rd_val = 32'(rr_regnum_r);
      tsd_pkg::OFF_CAUSE:
        rd_val = {14'h0000, cidx_r, cthread_r, 5'h00, cause_r};
      tsd_pkg::OFF_EVT_DATA: rd_val = evt_data_r;
      tsd_pkg::OFF_STOP_MASK: rd_val = 32'(stop_mask_r);
      default: rd_val = '0;
    endcase
  end

  always_comb
  begin
    rd_pend_nxt = ps_rd_i;
    rd_scr_nxt = ps_rd_i && hit_scr;
    rd_hold_nxt = ps_rd_i ? rd_val : rd_hold_r;
    rvalid_nxt = rd_pend_r;
    rdata_nxt = rdata_r;
    if (rd_pend_r)
    begin
      rdata_nxt = rd_scr_r ? scr_if.rd_a_data : rd_hold_r;
    end
    cfg_rvalid_nxt = cfg_rd_i;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_pend_r <= 1'b0;
      rd_scr_r <= 1'b0;
      rd_hold_r <= tsd_pkg::WORD_RST;
      rdata_r <= tsd_pkg::WORD_RST;
      rvalid_r <= 1'b0;
      cfg_rvalid_r <= 1'b0;
    end
    else
    begin
      rd_pend_r <= rd_pend_nxt;
      rd_scr_r <= rd_scr_nxt;
      rd_hold_r <= rd_hold_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      cfg_rvalid_r <= cfg_rvalid_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign ps_rdata_o = rdata_r;
  assign ps_rvalid_o = rvalid_r;
  // Memory output register drives the config read data directly
  assign cfg_rdata_o = scr_if.rd_b_data;
  assign cfg_rvalid_o = cfg_rvalid_r;
  assign core_osc_en_o = osc_ctrl_r[tsd_pkg::OSC_CORE_BIT];
  assign periph_osc_en_o = osc_ctrl_r[tsd_pkg::OSC_PERIPH_BIT];
  assign regread_thread_o = rr_thread_r;
  assign regread_regnum_o = rr_regnum_r;
  assign thread_stop_o = stop_out_r;

endmodule : tsd_status_bank

`default_nettype wire

// >>> common/tsd_pkg.sv
// Constants, offsets and field layouts of the tile status and debug bank
`default_nettype none

package tsd_pkg;

  // Processor status access port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets (processor status numbers)
  localparam logic [7:0] OFF_OSC_CTRL = 8'h06;
  localparam logic [7:0] OFF_CC_CNT = 8'h07;
  localparam logic [7:0] OFF_CW_CNT = 8'h08;
  localparam logic [7:0] OFF_PC_CNT = 8'h09;
  localparam logic [7:0] OFF_PW_CNT = 8'h0a;
  localparam logic [7:0] OFF_RAM_SIZE = 8'h0c;
  localparam logic [7:0] OFF_SSR_COPY = 8'h10;
  localparam logic [7:0] OFF_SPC_COPY = 8'h11;
  localparam logic [7:0] OFF_SSP_COPY = 8'h12;
  localparam logic [7:0] OFF_RR_THREAD = 8'h13;
  localparam logic [7:0] OFF_RR_REGNUM = 8'h14;
  localparam logic [7:0] OFF_CAUSE = 8'h15;
  localparam logic [7:0] OFF_EVT_DATA = 8'h16;
  localparam logic [7:0] OFF_STOP_MASK = 8'h18;
  localparam logic [7:0] OFF_SCR_FIRST = 8'h20;
  localparam logic [7:0] OFF_SCR_LAST = 8'h27;

  // Oscillator control fields
  localparam int OSC_CORE_BIT = 1;
  localparam int OSC_PERIPH_BIT = 0;
  localparam logic [1:0] OSC_CTRL_RST = 2'h0;
  localparam int OSC_NUM = 4;
  localparam int OSC_CNT_W = 16;
  // Software must wait this long after stopping an oscillator
  localparam int OSC_SETTLE_CYC = 10;

  // RAM size in bytes, bits 1:0 read as zero
  localparam logic [31:0] RAM_SIZE_BYTES = 32'h0001_0000;
  localparam logic [31:0] RAM_SIZE_MASK = 32'hffff_fffc;

  // Saved status copy layout
  localparam int SSR_W = 11;
  localparam logic [10:0] SSR_WR_MASK = 11'h6df;
  localparam logic [10:0] SSR_RST = 11'h000;

  // Register-read operand widths
  localparam int RR_THREAD_W = 8;
  localparam int RR_REGNUM_W = 5;

  // Debug cause register fields
  localparam int CAUSE_W = 3;
  localparam int CAUSE_LSB = 0;
  localparam int CTHREAD_LSB = 8;
  localparam int CTHREAD_W = 8;
  localparam int CIDX_LSB = 16;
  localparam int CIDX_W = 2;
  localparam logic [2:0] CAUSE_RST = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2;
  localparam logic [2:0] CAUSE_IBRK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;

  // Thread stop mask and scratch storage
  localparam int THREADS = 8;
  localparam int HIT_W = 4;
  localparam int SCR_DEPTH = 8;
  localparam int SCR_IDX_W = 3;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

endpackage : tsd_pkg

`default_nettype wire

// >>> common/tsd_scratch_if.sv
// Carrier between the bank and its scratch word memory
`default_nettype none

interface tsd_scratch_if;
  logic wr_en;
  logic [tsd_pkg::SCR_IDX_W-1:0] wr_idx;
  logic [tsd_pkg::DATA_W-1:0] wr_data;
  logic [tsd_pkg::SCR_IDX_W-1:0] rd_a_idx;
  logic [tsd_pkg::DATA_W-1:0] rd_a_data;
  logic [tsd_pkg::SCR_IDX_W-1:0] rd_b_idx;
  logic [tsd_pkg::DATA_W-1:0] rd_b_data;

  modport user (
    output wr_en, wr_idx, wr_data, rd_a_idx, rd_b_idx,
    input rd_a_data, rd_b_data
  );
  modport mem (
    input wr_en, wr_idx, wr_data, rd_a_idx, rd_b_idx,
    output rd_a_data, rd_b_data
  );
endinterface : tsd_scratch_if

`default_nettype wire

// >>> verilog/tsd_scratch_mem.sv
// Eight scratch words, one write port and two registered read ports
`default_nettype none

module tsd_scratch_mem (
  input wire logic sys_clk_i,
  tsd_scratch_if.mem mem_if
);

  logic [tsd_pkg::DATA_W-1:0] word_r [tsd_pkg::SCR_DEPTH];
  logic [tsd_pkg::DATA_W-1:0] rd_a_nxt;
  logic [tsd_pkg::DATA_W-1:0] rd_b_nxt;
  logic [tsd_pkg::DATA_W-1:0] rd_a_r;
  logic [tsd_pkg::DATA_W-1:0] rd_b_r;

  // Read before write: a same-cycle write shows on the next read
  always_comb
  begin
    rd_a_nxt = word_r[mem_if.rd_a_idx];
    rd_b_nxt = word_r[mem_if.rd_b_idx];
  end

  // Storage has no reset, like a RAM
  always_ff @(posedge sys_clk_i)
  begin
    if (mem_if.wr_en)
    begin
      word_r[mem_if.wr_idx] <= mem_if.wr_data;
    end
    rd_a_r <= rd_a_nxt;
    rd_b_r <= rd_b_nxt;
  end

  assign mem_if.rd_a_data = rd_a_r;
  assign mem_if.rd_b_data = rd_b_r;

endmodule : tsd_scratch_mem

`default_nettype wire

// >>> verif/tsd_osc_src.sv
// Ring oscillator source model driving the bank's oscillator inputs
`default_nettype none

module tsd_osc_src (
  input wire logic core_en_i,
  input wire logic periph_en_i,
  output var logic [3:0] ring_osc_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Period off the core clock grid, so the phase drifts as a real ring would
  initial ring_osc_o = 4'h0;
  always #7.3 ring_osc_o = ring_osc_o ^ {{2{periph_en_i}}, {2{core_en_i}}};
endmodule : tsd_osc_src

`default_nettype wire

// >>> verif/tsd_status_bank_sva.sv
// Concurrent checks on the ports of the status and debug bank
`default_nettype none

module tsd_status_bank_sva (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ps_wr_i,
  input wire logic ps_rd_i,
  input wire logic [7:0] ps_addr_i,
  input wire logic [31:0] ps_wdata_i,
  input wire logic [31:0] ps_rdata_o,
  input wire logic ps_rvalid_o,
  input wire logic cfg_rd_i,
  input wire logic cfg_rvalid_o,
  input wire logic dbg_mode_i,
  input wire logic core_osc_en_o,
  input wire logic periph_osc_en_o,
  input wire logic [7:0] regread_thread_o,
  input wire logic [4:0] regread_regnum_o,
  input wire logic [7:0] thread_stop_o
);
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Answer timing of both ports
  chk_read_latency: assert property (ps_rd_i |-> ##2 ps_rvalid_o)
    else $error("status read answer missing");
  chk_scratch_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("scratch read answer missing");
  // Oscillator enables follow control writes only
  chk_osc_enable_set:
    assert property (ps_wr_i && ps_addr_i == 8'h06 |=>
      {core_osc_en_o, periph_osc_en_o} == $past(ps_wdata_i[1:0]))
    else $error("oscillator enables differ from write");
  chk_osc_enable_hold:
    assert property (!(ps_wr_i && ps_addr_i == 8'h06) |=>
      $stable({core_osc_en_o, periph_osc_en_o}))
    else $error("oscillator enables changed without write");
  // Constant and unmapped reads
  chk_ram_size:
    assert property (ps_rd_i && ps_addr_i == 8'h0c |-> ##2
      ps_rdata_o == (tsd_pkg::RAM_SIZE_BYTES & tsd_pkg::RAM_SIZE_MASK))
    else $error("ram size read wrong");
  chk_unmapped_zero:
    assert property (ps_rd_i && ps_addr_i == 8'h0b |-> ##2 ps_rdata_o == 0)
    else $error("unmapped read not zero");
  // Operand registers written in debug mode, frozen outside it
  chk_thread_write:
    assert property (dbg_mode_i && ps_wr_i && ps_addr_i == 8'h13 |=>
      regread_thread_o == $past(ps_wdata_i[7:0]))
    else $error("thread operand not written");
  chk_regnum_write:
    assert property (dbg_mode_i && ps_wr_i && ps_addr_i == 8'h14 |=>
      regread_regnum_o == $past(ps_wdata_i[4:0]))
    else $error("register operand not written");
  chk_operand_lock:
    assert property (!dbg_mode_i |=>
      $stable({regread_thread_o, regread_regnum_o}))
    else $error("operand changed outside debug mode");
  // No thread is held while in debug mode
  chk_stop_in_debug: assert property (dbg_mode_i |=> thread_stop_o == 0)
    else $error("thread held during debug mode");
endmodule : tsd_status_bank_sva

bind tsd_status_bank tsd_status_bank_sva chk_u (.sys_clk_i, .rstn_i,
  .ps_wr_i, .ps_rd_i, .ps_addr_i, .ps_wdata_i, .ps_rdata_o, .ps_rvalid_o,
  .cfg_rd_i, .cfg_rvalid_o, .dbg_mode_i, .core_osc_en_o, .periph_osc_en_o,
  .regread_thread_o, .regread_regnum_o, .thread_stop_o);

`default_nettype wire

// >>> verif/tsd_status_bank_bench.sv
// Self-checking bench for the tile status and debug bank
`default_nettype none

module tsd_status_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rstn, ps_wr, ps_rd, ps_rv, cfg_wr, cfg_rd, cfg_rv, dmode, dent;
  logic core_en, per_en;
  logic [7:0] ps_addr, dthr, rr_thr, stop;
  logic [31:0] ps_wd, ps_rdata, cfg_wd, cfg_rdata, daddr, dres, dpc, dsp;
  logic [31:0] cnt [4];
  logic [2:0] cfg_idx, dcause;
  logic [3:0] dhit, ring;
  logic [10:0] dsr;
  logic [4:0] rr_reg;
  int failures, checks, cyc;

  tsd_status_bank dut_u (.sys_clk_i(clk), .rstn_i(rstn), .ps_wr_i(ps_wr),
    .ps_rd_i(ps_rd), .ps_addr_i(ps_addr), .ps_wdata_i(ps_wd),
    .ps_rdata_o(ps_rdata), .ps_rvalid_o(ps_rv), .cfg_wr_i(cfg_wr),
    .cfg_rd_i(cfg_rd), .cfg_idx_i(cfg_idx), .cfg_wdata_i(cfg_wd),
    .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rv), .dbg_mode_i(dmode),
    .dbg_enter_i(dent), .dbg_cause_i(dcause), .dbg_thread_i(dthr),
    .dbg_hit_i(dhit), .dbg_addr_i(daddr), .dbg_res_i(dres), .dbg_sr_i(dsr),
    .dbg_pc_i(dpc), .dbg_sp_i(dsp), .ring_osc_i(ring),
    .core_osc_en_o(core_en), .periph_osc_en_o(per_en),
    .regread_thread_o(rr_thr), .regread_regnum_o(rr_reg),
    .thread_stop_o(stop));

  tsd_osc_src osc_u (.core_en_i(core_en), .periph_en_i(per_en),
    .ring_osc_o(ring));

  // Clock at 125 MHz
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic ps_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    ps_wr = 1'b1;
    ps_addr = a;
    ps_wd = d;
    @(negedge clk);
    ps_wr = 1'b0;
  endtask : ps_write

  // Answer stands for one cycle only, looked at on the second falling edge
  task automatic ps_read(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    ps_rd = 1'b1;
    ps_addr = a;
    @(negedge clk);
    ps_rd = 1'b0;
    @(negedge clk);
    chk("read valid", 32'h1, {31'h0, ps_rv});
    d = ps_rdata;
  endtask : ps_read

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] d;
    ps_read(a, d);
    chk(nm, exp, d);
  endtask : rdchk

  task automatic cfg_access(input logic w, input logic [2:0] i,
                            input logic [31:0] d);
    @(negedge clk);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_idx = i;
    cfg_wd = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    if (!w)
    begin
      chk("scratch valid", 32'h1, {31'h0, cfg_rv});
      chk("scratch data", d, cfg_rdata);
    end
  endtask : cfg_access

  task automatic t_osc();
    rdchk("osc control", 8'h06, 32'h0);
    rdchk("ram size", 8'h0c, 32'h0001_0000);
    rdchk("unmapped", 8'h0b, 32'h0);
    ps_write(8'h06, 32'hffff_ffff);
    chk("enables", 32'h3, {30'h0, core_en, per_en});
    rdchk("osc control", 8'h06, 32'h3);
    repeat (40) @(negedge clk);
    ps_write(8'h06, 32'h2);
    chk("enables", 32'h2, {30'h0, core_en, per_en});
    ps_write(8'h06, 32'h0);
    // Stopped counts need ten quiet cycles before reading
    repeat (10) @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      ps_read(8'h07 + i[7:0], cnt[i]);
      chk("count upper", 32'h0, {16'h0, cnt[i][31:16]});
      chk("count moved", 32'h1, {31'h0, cnt[i] != 32'h0});
    end
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 4; i++)
      rdchk("count kept", 8'h07 + i[7:0], cnt[i]);
  endtask : t_osc

  task automatic t_capture();
    logic [1:0] idx;
    dmode = 1'b1;
    for (int c = 1; c <= 5; c++)
    begin
      @(negedge clk);
      dent = 1'b1;
      dcause = c[2:0];
      dthr = 8'h40 + c[7:0];
      dhit = c[0] ? 4'b1010 : 4'b1100;
      dsr = 11'h7f0 | c[10:0];
      dpc = 32'h1000_0000 + c;
      dsp = 32'h2000_0000 + c;
      daddr = 32'hadd0_0000 + c;
      dres = 32'h0e50_0000 + c;
      @(negedge clk);
      dent = 1'b0;
      idx = (c < 3) ? 2'h0 : (c[0] ? 2'h1 : 2'h2);
      rdchk("cause", 8'h15, {14'h0, idx, (c == 1) ? 8'h0 : dthr,
        5'h0, c[2:0]});
      rdchk("status copy", 8'h10, {21'h0, dsr & 11'h7df});
      rdchk("pc copy", 8'h11, dpc);
      rdchk("sp copy", 8'h12, dsp);
      rdchk("event data", 8'h16, (c == 4) ? daddr :
        (c == 5) ? dres : 32'h0);
    end
  endtask : t_capture

  task automatic t_access();
    dmode = 1'b0;
    ps_write(8'h15, 32'h0);
    ps_write(8'h11, 32'h0);
    ps_write(8'h13, 32'hffff_ffff);
    rdchk("cause locked", 8'h15, 32'h0001_4505);
    rdchk("pc locked", 8'h11, 32'h1000_0005);
    rdchk("thread locked", 8'h13, 32'h0);
    dmode = 1'b1;
    ps_write(8'h13, 32'hffff_ffff);
    ps_write(8'h14, 32'hffff_ffff);
    ps_write(8'h10, 32'hffff_ffff);
    ps_write(8'h15, 32'hffff_ffff);
    chk("operand pins", 32'h1fff, {19'h0, rr_reg, rr_thr});
    rdchk("thread operand", 8'h13, 32'h0000_00ff);
    rdchk("register operand", 8'h14, 32'h0000_001f);
    rdchk("status copy", 8'h10, 32'h0000_07df);
    ps_write(8'h10, 32'h0);
    rdchk("status copy", 8'h10, 32'h0000_0100);
    rdchk("cause", 8'h15, 32'h0003_ff07);
  endtask : t_access

  task automatic t_stop();
    ps_write(8'h18, 32'hffff_ffa5);
    chk("held in debug", 32'h0, {24'h0, stop});
    dmode = 1'b0;
    repeat (2) @(negedge clk);
    chk("held threads", 32'h0000_00a5, {24'h0, stop});
    rdchk("stop mask", 8'h18, 32'h0000_00a5);
  endtask : t_stop

  task automatic t_scratch();
    dmode = 1'b1;
    for (int i = 0; i < 8; i++)
      ps_write(8'h20 + i[7:0], 32'hc0de_0000 + i);
    for (int i = 0; i < 8; i++)
      cfg_access(1'b0, i[2:0], 32'hc0de_0000 + i);
    for (int i = 0; i < 8; i++)
      cfg_access(1'b1, i[2:0], 32'hfeed_0000 + i);
    for (int i = 0; i < 8; i++)
      rdchk("scratch", 8'h20 + i[7:0], 32'hfeed_0000 + i);
    dmode = 1'b0;
    ps_write(8'h20, 32'h0);
    cfg_access(1'b0, 3'h0, 32'hfeed_0000);
  endtask : t_scratch

  // Main sequence
  initial
  begin
    {rstn, ps_wr, ps_rd, cfg_wr, cfg_rd, dmode, dent} = 7'h00;
    {ps_addr, ps_wd, cfg_idx, cfg_wd, dcause, dthr, dhit} = '0;
    {daddr, dres, dsr, dpc, dsp} = '0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_osc();
    t_capture();
    t_access();
    t_stop();
    t_scratch();
    wrap_up();
  end
endmodule : tsd_status_bank_bench

`default_nettype wire
